// ---- src/mem_port_map.svh ----
`ifndef MEM_PORT_MAP_SVH
`define MEM_PORT_MAP_SVH
`define WBUF_DEPTH      4
`define PEND_DEPTH      4
`define TGT_L1D         2'h0
`define TGT_L1P         2'h1
`define TGT_L2          2'h2
`define TGT_CFG         2'h3
`define OUT_ALLOC       2'h0
`define OUT_WBACK       2'h1
`define OUT_NC_READ     2'h2
`define OUT_NC_WRITE    2'h3
`endif

// ---- src/mem_port_pkg.sv ----
package mem_port_pkg;
   typedef logic [31:0] word_t;
   typedef logic [1:0]  target_t;
   typedef logic [1:0]  out_kind_t;
   typedef enum logic [1:0] {SRC_NONE, SRC_SLAVE, SRC_CORE_INTERNAL_DMA} src_t;
endpackage

// ---- src/wbuf_if.sv ----
`timescale 1ns/100ps
interface wbuf_if;
   logic             push_valid;
   logic             push_ready;
   logic [63:0]      push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [63:0]      pop_data;
   logic             full;
   modport owner (output push_valid, push_data, pop_ready,
                  input  push_ready, pop_valid, pop_data, full);
   modport buffer (input  push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, full);
endinterface

// ---- src/nc_write_buffer.sv ----
`timescale 1ns/100ps
`include "mem_port_map.svh"
module nc_write_buffer #(
   parameter int DEPTH = `WBUF_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   wbuf_if.buffer   wb
);
   import mem_port_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][63:0] mem;
      logic [AW-1:0]          wr;
      logic [AW-1:0]          rd;
      logic [AW:0]            cnt;
   } wb_state_t;
   wb_state_t s_q;
   wb_state_t s_d;
   logic push;
   logic pop;
   always_comb
   begin
      s_d  = s_q;
      pop  = wb.pop_ready && (s_q.cnt != '0);
      push = wb.push_valid && (s_q.cnt != (AW+1)'(DEPTH));
      if (push)
      begin
         s_d.mem[s_q.wr] = wb.push_data;
         s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop)
         s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign wb.push_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign wb.full       = (s_q.cnt == (AW+1)'(DEPTH));
   assign wb.pop_valid  = (s_q.cnt != '0);
   assign wb.pop_data   = s_q.mem[s_q.rd];
endmodule

// ---- src/mem_port_arbiter.sv ----
`timescale 1ns/100ps
`include "mem_port_map.svh"
module mem_port_arbiter #(
   parameter int PEND = `PEND_DEPTH
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   // configuration
   input  wire logic                  l2_all_cache,
   // core non-cacheable / cache requests toward outbound port
   input  wire logic                  core_valid,
   input  wire mem_port_pkg::out_kind_t core_kind,
   input  wire mem_port_pkg::word_t   core_addr,
   input  wire mem_port_pkg::word_t   core_wdata,
   output logic                       core_ready,
   // first-level data cache victims
   input  wire logic                  l1d_victim_valid,
   input  wire mem_port_pkg::word_t   l1d_victim_addr,
   output logic                       l1d_victim_ready,
   // second-level cache victims
   input  wire logic                  l2_victim_valid,
   input  wire mem_port_pkg::word_t   l2_victim_addr,
   output logic                       l2_victim_ready,
   // inbound slave port
   input  wire logic                  slv_valid,
   input  wire mem_port_pkg::target_t slv_target,
   output logic                       slv_ready,
   // internal dma
   input  wire logic                  core_internal_dma_valid,
   input  wire mem_port_pkg::target_t core_internal_dma_target,
   output logic                       core_internal_dma_ready,
   // second-level memory completion of queued accesses
   input  wire logic                  l2_done,
   // internal memory access toward first/second level
   output logic                       mem_valid,
   output mem_port_pkg::target_t      mem_target,
   output mem_port_pkg::src_t         mem_src,
   // l1d victim delivered to second level
   output logic                       l2_fill_valid,
   output mem_port_pkg::word_t        l2_fill_addr,
   // outbound master port
   output logic                       out_valid,
   output mem_port_pkg::out_kind_t    out_kind,
   output mem_port_pkg::word_t        out_addr,
   output mem_port_pkg::word_t        out_wdata,
   input  wire logic                  out_ready,
   output logic [$clog2(PEND+1)-1:0]  out_pending,
   input  wire logic                  out_resp
);
   import mem_port_pkg::*;
   localparam int PW = $clog2(PEND+1);

   // ==================================================
   // reset release
   logic [1:0] rst_sync_q;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'h1};
   end
   wire rst_n = rst_sync_q[1];

   // ==================================================
   // non-cacheable write buffer
   wbuf_if wb ();
   nc_write_buffer #(.DEPTH(`WBUF_DEPTH)) u_wbuf (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wb      (wb.buffer)
   );

   function automatic logic is_l2(input target_t t);
      is_l2 = (t == `TGT_L2);
   endfunction

   typedef enum logic [1:0] {OUT_IDLE, OUT_BUSY} out_st_t;

   typedef struct packed {
      logic          out_valid;
      out_kind_t     out_kind;
      word_t         out_addr;
      word_t         out_wdata;
      logic          from_wbuf;
      out_st_t       ost;
      logic [PW-1:0] pend;
      logic [PW-1:0] l2_q;
      logic          mem_valid;
      target_t       mem_target;
      src_t          mem_src;
      logic          l2_fill_valid;
      word_t         l2_fill_addr;
      logic          core_ready;
      logic          l1d_victim_ready;
      logic          l2_victim_ready;
      logic          slv_ready;
      logic          core_internal_dma_ready;
   } st_t;
   st_t s_q;
   st_t s_d;

   logic block_dma;
   logic slv_stall;
   logic core_internal_dma_stall;
   logic nc_wr;
   logic take_core;
   logic take_l2v;
   logic take_slv;
   logic take_core_internal_dma;
   logic l2_access;

   // ==================================================
   // arbitration
   always_comb
   begin
      s_d = s_q;
      wb.pop_ready  = 1'b0;
      wb.push_valid = 1'b0;
      wb.push_data  = {core_addr, core_wdata};
      take_core = 1'b0;
      take_l2v  = 1'b0;
      take_slv  = 1'b0;
      take_core_internal_dma = 1'b0;
      l2_access = 1'b0;
      nc_wr = core_valid && (core_kind == `OUT_NC_WRITE);
      // extra blocking only when second level is partly ram; all cache never blocks
      block_dma = wb.full && !l2_all_cache;
      // first-level access stalls on block_dma and behind queued second-level ones
      slv_stall  = block_dma || (s_q.l2_q != '0 && !is_l2(slv_target))
                   || (is_l2(slv_target) && s_q.l2_q == PW'(PEND));
      // internal dma never waits on outbound traffic beyond the buffer,
      // so it cannot close a loop through the interconnect
      core_internal_dma_stall = block_dma || (s_q.l2_q != '0 && !is_l2(core_internal_dma_target))
                   || (is_l2(core_internal_dma_target) && s_q.l2_q == PW'(PEND));
      // l1d victims always land in second level, never outbound
      s_d.l2_fill_valid    = l1d_victim_valid;
      s_d.l2_fill_addr     = l1d_victim_addr;
      s_d.l1d_victim_ready = 1'b1;
      // slave port first, core_internal_dma shares the same single access slot
      s_d.mem_valid = 1'b0;
      if (slv_valid && !slv_stall && !s_q.slv_ready)
      begin
         take_slv = 1'b1;
         s_d.mem_valid  = 1'b1;
         s_d.mem_target = slv_target;
         s_d.mem_src    = SRC_SLAVE;
         l2_access      = is_l2(slv_target) && !l2_all_cache;
      end
      else if (core_internal_dma_valid && !core_internal_dma_stall && !s_q.core_internal_dma_ready)
      begin
         take_core_internal_dma = 1'b1;
         s_d.mem_valid  = 1'b1;
         s_d.mem_target = core_internal_dma_target;
         s_d.mem_src    = SRC_CORE_INTERNAL_DMA;
         l2_access      = is_l2(core_internal_dma_target) && !l2_all_cache;
      end
      else
         s_d.mem_src = SRC_NONE;
      s_d.slv_ready  = take_slv;
      s_d.core_internal_dma_ready = take_core_internal_dma;
      s_d.l2_q = s_q.l2_q + PW'(l2_access) - PW'(l2_done && s_q.l2_q != '0);
      // core non-cacheable writes go through the buffer
      if (nc_wr && wb.push_ready && !s_q.core_ready)
      begin
         wb.push_valid = 1'b1;
         take_core = 1'b1;
      end
      // outbound launch; a buffered write keeps its entry until the far side takes it,
      // so the write in flight still counts against the four
      if (s_q.out_valid && out_ready)
      begin
         s_d.out_valid = 1'b0;
         s_d.from_wbuf = 1'b0;
         wb.pop_ready  = s_q.from_wbuf;
      end
      if (!s_d.out_valid && s_q.pend != PW'(PEND))
      begin
         if (l2_victim_valid && !s_q.l2_victim_ready)
         begin
            take_l2v = 1'b1;
            s_d.out_valid = 1'b1;
            s_d.out_kind  = `OUT_WBACK;
            s_d.out_addr  = l2_victim_addr;
            s_d.out_wdata = '0;
         end
         else if (wb.pop_valid && !wb.pop_ready)
         begin
            s_d.from_wbuf = 1'b1;
            s_d.out_valid = 1'b1;
            s_d.out_kind  = `OUT_NC_WRITE;
            s_d.out_addr  = wb.pop_data[63:32];
            s_d.out_wdata = wb.pop_data[31:0];
         end
         // buffered writes leave first, so a later load never passes them
         else if (core_valid && !nc_wr && !s_q.core_ready && !wb.pop_valid)
         begin
            take_core = 1'b1;
            s_d.out_valid = 1'b1;
            s_d.out_kind  = core_kind;
            s_d.out_addr  = core_addr;
            s_d.out_wdata = core_wdata;
         end
      end
      s_d.pend = s_q.pend + PW'(s_q.out_valid && out_ready) - PW'(out_resp && s_q.pend != '0);
      s_d.core_ready      = take_core;
      s_d.l2_victim_ready = take_l2v;
      case (s_q.ost)
         OUT_IDLE: s_d.ost = s_d.out_valid ? OUT_BUSY : OUT_IDLE;
         OUT_BUSY: s_d.ost = s_d.out_valid ? OUT_BUSY : OUT_IDLE;
         default:  s_d.ost = OUT_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ==================================================
   // outputs
   assign core_ready       = s_q.core_ready;
   assign l1d_victim_ready = s_q.l1d_victim_ready;
   assign l2_victim_ready  = s_q.l2_victim_ready;
   assign slv_ready        = s_q.slv_ready;
   assign core_internal_dma_ready       = s_q.core_internal_dma_ready;
   assign mem_valid        = s_q.mem_valid;
   assign mem_target       = s_q.mem_target;
   assign mem_src          = s_q.mem_src;
   assign l2_fill_valid    = s_q.l2_fill_valid;
   assign l2_fill_addr     = s_q.l2_fill_addr;
   assign out_valid        = s_q.out_valid;
   assign out_kind         = s_q.out_kind;
   assign out_addr         = s_q.out_addr;
   assign out_wdata        = s_q.out_wdata;
   assign out_pending      = s_q.pend;
endmodule

// ---- testbench/mem_port_checker.sv ----
`timescale 1ns/100ps
`include "mem_port_map.svh"
module mem_port_checker #(
   parameter int PEND = 4
) (
   // clock, reset, config
   input wire logic                     ref_clk,
   input wire logic                     reset_n,
   input wire logic                     l2_all_cache,
   // requesters
   input wire mem_port_pkg::out_kind_t  core_kind,
   input wire logic                     core_ready,
   input wire logic                     l1d_victim_valid,
   input wire mem_port_pkg::word_t      l1d_victim_addr,
   input wire logic                     l1d_victim_ready,
   input wire logic                     slv_valid,
   input wire logic                     slv_ready,
   input wire logic                     core_internal_dma_ready,
   // results
   input wire logic                     mem_valid,
   input wire mem_port_pkg::src_t       mem_src,
   input wire logic                     l2_fill_valid,
   input wire mem_port_pkg::word_t      l2_fill_addr,
   input wire logic                     out_valid,
   input wire mem_port_pkg::out_kind_t  out_kind,
   input wire logic                     out_ready,
   input wire logic [$clog2(PEND+1)-1:0] out_pending
);
   import mem_port_pkg::*;
   // ====================
   // buffer occupancy
   // counts only on handshakes, so it lags the real buffer, never leads it
   logic [3:0] occ_q;
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
         occ_q <= 4'h0;
      else
         occ_q <= occ_q + 4'(core_ready && core_kind == `OUT_NC_WRITE)
                  - 4'(out_valid && out_ready && out_kind == `OUT_NC_WRITE);
   // ====================
   // properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_depth; occ_q <= 4'h4; endproperty
   property p_block; occ_q == 4'h4 && !l2_all_cache && !(out_valid && out_ready)
      |=> !slv_ready && !core_internal_dma_ready; endproperty
   property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_kind); endproperty
   property p_kind; core_ready && core_kind != `OUT_NC_WRITE |-> out_valid
      && out_kind == core_kind; endproperty
   property p_slv; slv_ready |-> mem_valid && mem_src == SRC_SLAVE && $past(slv_valid);
   endproperty
   property p_core_internal_dma; core_internal_dma_ready |-> mem_valid && mem_src == SRC_CORE_INTERNAL_DMA && !slv_ready;
   endproperty
   property p_grant; mem_valid |-> slv_ready || core_internal_dma_ready; endproperty
   property p_fill; l1d_victim_valid && l1d_victim_ready |=> l2_fill_valid
      && l2_fill_addr == $past(l1d_victim_addr); endproperty
   property p_pend; out_pending <= PEND; endproperty
   a_depth: assert property (p_depth) else $error("buffer above four");
   a_block: assert property (p_block) else $error("grant while buffer full");
   a_hold: assert property (p_hold) else $error("outbound request dropped");
   a_kind: assert property (p_kind) else $error("core request not issued");
   a_slv: assert property (p_slv) else $error("bad slave grant");
   a_core_internal_dma: assert property (p_core_internal_dma) else $error("bad dma grant");
   a_grant: assert property (p_grant) else $error("access without grant");
   a_fill: assert property (p_fill) else $error("victim not sent down");
   a_pend: assert property (p_pend) else $error("too many pending");
   c_full: cover property (occ_q == 4'h4);
   c_cache: cover property (slv_ready && l2_all_cache);
   c_fill: cover property (l2_fill_valid);
endmodule
bind mem_port_arbiter mem_port_checker #(.PEND(PEND)) mem_port_checker_i (.*);

// ---- testbench/out_port_model.sv ----
`timescale 1ns/100ps
module out_port_model (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       reset_n,
   // outbound port
   input wire logic       out_valid,
   output logic           out_ready,
   output logic           out_resp,
   // 0 prompt, 1 random stalls, 2 hold off
   input wire logic [1:0] mode
);
   logic [7:0] lfsr_q;
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
         lfsr_q    <= 8'h5a;
         out_ready <= 1'b0;
         out_resp  <= 1'b0;
      end
      else
      begin
         lfsr_q    <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         out_ready <= mode == 2'h0 || (mode == 2'h1 && lfsr_q[0]);
         // every accepted transfer completes one cycle later
         out_resp  <= out_valid && out_ready;
      end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`include "mem_port_map.svh"
module tb;
   import mem_port_pkg::*;
   logic ref_clk, reset_n, l2_all_cache, core_valid, core_ready, l1d_victim_valid;
   logic l1d_victim_ready, l2_victim_valid, l2_victim_ready, slv_valid, slv_ready;
   logic core_internal_dma_valid, core_internal_dma_ready, l2_done, mem_valid, l2_fill_valid, out_valid;
   logic out_ready, out_resp;
   logic [1:0] mode;
   logic [2:0] out_pending;
   out_kind_t  core_kind, out_kind;
   word_t      core_addr, core_wdata, l1d_victim_addr, l2_victim_addr;
   word_t      l2_fill_addr, out_addr, out_wdata;
   target_t    slv_target, core_internal_dma_target, mem_target;
   src_t       mem_src;
   logic [65:0] oq[$];
   logic [3:0]  mq[$];
   word_t       fq[$];
   int          mismatches = 0, num_checks = 0, cyc = 0;
   logic [31:0] rs = 32'h125a;
   mem_port_arbiter mem_port_arbiter_i (.*);
   out_port_model out_port_model_i (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // ====================
   // helpers
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic check(input logic [65:0] seen, input logic [65:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_rdy(ref logic r, output bit ok);
      int n;
      n = 0;
      do @(posedge ref_clk) n++; while (r !== 1'b1 && n < 200);
      ok = r === 1'b1;
   endtask
   task automatic core_req(input out_kind_t k, input word_t a);
      bit ok;
      @(posedge ref_clk);
      core_valid <= 1'b1;
      core_kind  <= k;
      core_addr  <= a;
      core_wdata <= ~a;
      oq.push_back({k, a, ~a});
      wait_rdy(core_ready, ok);
      check(ok, 1'b1);
      core_valid <= 1'b0;
   endtask
   task automatic acc(input bit dma, input target_t t, input bit done);
      bit ok;
      @(posedge ref_clk);
      slv_valid   <= !dma;
      core_internal_dma_valid  <= dma;
      slv_target  <= t;
      core_internal_dma_target <= t;
      mq.push_back({dma ? SRC_CORE_INTERNAL_DMA : SRC_SLAVE, t});
      if (dma)
         wait_rdy(core_internal_dma_ready, ok);
      else
         wait_rdy(slv_ready, ok);
      check(ok, 1'b1);
      slv_valid  <= 1'b0;
      core_internal_dma_valid <= 1'b0;
      l2_done    <= done && t == `TGT_L2;
      @(posedge ref_clk);
      l2_done <= 1'b0;
   endtask
   // ====================
   // result watcher and timeout
   always @(posedge ref_clk)
   begin
      if (out_valid === 1'b1 && out_ready === 1'b1)
         check({out_kind, out_addr, out_wdata}, oq.size() ? oq.pop_front() : 'x);
      if (mem_valid === 1'b1)
         check({mem_src, mem_target}, mq.size() ? mq.pop_front() : 'x);
      if (l2_fill_valid === 1'b1)
         check(l2_fill_addr, fq.size() ? fq.pop_front() : 'x);
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   // ====================
   // scenarios
   initial
   begin
      int i;
      bit ok;
      logic hit;
      word_t r;
      reset_n = 1'b0;
      {l2_all_cache, core_valid, l1d_victim_valid, l2_victim_valid} = '0;
      {slv_valid, core_internal_dma_valid, l2_done, mode, core_kind, core_addr, core_wdata} = '0;
      {l1d_victim_addr, l2_victim_addr, slv_target, core_internal_dma_target} = '0;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      // four writes fill the buffer while the far side holds off
      mode <= 2'h2;
      for (i = 0; i < 4; i++)
         core_req(`OUT_NC_WRITE, rnd());
      fork
         core_req(`OUT_NC_WRITE, rnd());
         begin
            @(posedge ref_clk);
            slv_valid  <= 1'b1;
            slv_target <= `TGT_L1D;
            hit = 1'b0;
            repeat (20) @(posedge ref_clk) hit |= core_ready | slv_ready;
            check(hit, 1'b0);
            l2_all_cache <= 1'b1;
            mq.push_back({SRC_SLAVE, `TGT_L1D});
            wait_rdy(slv_ready, ok);
            check(ok, 1'b1);
            slv_valid    <= 1'b0;
            l2_all_cache <= 1'b0;
            mode         <= 2'h0;
         end
      join
      for (i = 0; i < 3; i++)
         core_req(out_kind_t'(i), rnd());
      @(posedge ref_clk);
      r = rnd();
      l2_victim_valid <= 1'b1;
      l2_victim_addr  <= r;
      // victims carry no data word on this port
      oq.push_back({`OUT_WBACK, r, 32'h0});
      wait_rdy(l2_victim_ready, ok);
      check(ok, 1'b1);
      l2_victim_valid  <= 1'b0;
      l1d_victim_valid <= 1'b1;
      l1d_victim_addr  <= ~r;
      fq.push_back(~r);
      wait_rdy(l1d_victim_ready, ok);
      check(ok, 1'b1);
      l1d_victim_valid <= 1'b0;
      for (i = 0; i < 8; i++)
         acc(i[0], target_t'(i >> 1), 1'b1);
      // first-level access queued behind an unfinished second-level one
      acc(1'b0, `TGT_L2, 1'b0);
      core_internal_dma_valid  <= 1'b1;
      core_internal_dma_target <= `TGT_L1D;
      hit = 1'b0;
      repeat (10) @(posedge ref_clk) hit |= core_internal_dma_ready;
      check(hit, 1'b0);
      l2_done <= 1'b1;
      mq.push_back({SRC_CORE_INTERNAL_DMA, `TGT_L1D});
      @(posedge ref_clk);
      l2_done <= 1'b0;
      wait_rdy(core_internal_dma_ready, ok);
      check(ok, 1'b1);
      core_internal_dma_valid <= 1'b0;
      mode <= 2'h1;
      repeat (40)
      begin
         r = rnd();
         if (r[0])
            core_req(`OUT_NC_WRITE, r);
         else
            acc(r[1], target_t'(r[3:2]), 1'b1);
      end
      mode <= 2'h0;
      repeat (50) @(posedge ref_clk);
      check(oq.size() + mq.size() + fq.size(), 0);
      end_of_test();
   end
endmodule
